// ### tb/pirl_host.sv
// host model issuing register writes and reads
`timescale 1ns/100ps
module pirl_host(
  input wire ref_clk, input wire [15:0] regRdata, output reg regWrite, output reg regRead,
  output reg [6:0] regAddr, output reg [15:0] regWdata, output reg [1:0] regByteEn
);
  initial {regWrite, regRead, regAddr, regWdata, regByteEn} = 0;
  task wr(input [15:0] d, input [1:0] b);
  begin
    @(posedge ref_clk);
    {regWrite, regAddr, regWdata, regByteEn} <= {1'b1, 7'h74, d, b};
    @(posedge ref_clk);
    regWrite <= 1'b0;
    // released data is inverted so a stale value cannot pass
    regWdata <= ~d;
  end
  endtask
  task rd(input [6:0] a, output [15:0] q);
  begin
    @(posedge ref_clk);
    {regRead, regAddr} <= {1'b1, a};
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 q = regRdata;
  end
  endtask
endmodule // pirl_host

// ### tb/pirl_props.sv
// port checks for the rate limiter
`timescale 1ns/100ps
module pirl_props(
  input wire ref_clk, resetn, regWrite, regRead, frameStart, frameBroadcast,
  input wire frameAccept, frameDrop, input wire [6:0] regAddr,
  input wire [15:0] regWdata, regRdata, input wire [1:0] regByteEn, limitMode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_one_answer: assert property (frameStart |=> frameAccept ^ frameDrop)
    else $error("no single answer");
  a_no_answer: assert property (!frameStart |=> !frameAccept && !frameDrop)
    else $error("stray answer");
  a_rsv_zero: assert property (!regRdata[15] && !regRdata[7])
    else $error("reserved bit set");
  a_unmapped_read: assert property (regRead && regAddr != 7'h74 |=> regRdata == 0)
    else $error("unmapped read");
  a_rdata_holds: assert property (!regRead |=> $stable(regRdata))
    else $error("read data moved");
  a_mode_bypass: assert property (frameStart && limitMode == 2'b11 && !frameBroadcast
    |=> frameAccept) else $error("bypass dropped");
  a_word_back: assert property (regWrite && regAddr == 7'h74 && regByteEn == 2'b11
    ##2 regRead && regAddr == 7'h74 |=> regRdata == ($past(regWdata, 3) & 16'h7f7f))
    else $error("bad readback");
  a_low_lane: assert property (regWrite && regAddr == 7'h74 && regByteEn == 2'b01
    ##2 regRead && regAddr == 7'h74 |=> regRdata[6:0] == $past(regWdata[6:0], 3))
    else $error("bad low lane");
  cover property (frameDrop);
  cover property (frameAccept && limitMode == 2'b11);
  cover property (regWrite && regByteEn == 2'b01);
endmodule // pirl_props
bind pirl_port_ingress_rate_limiter pirl_props pirl_props_inst (.*);

// ### tb/tb_pirl_port_ingress_rate_limiter.sv
// self-checking bench for the port 1 ingress rate limiter
`timescale 1ns/100ps
module tb_pirl_port_ingress_rate_limiter;
  reg ref_clk = 0, resetn = 0, linkIs100 = 1, countIfg = 0, countPreamble = 0;
  reg frameStart = 0, framePriority = 0, frameBroadcast = 0, frameMulticast = 0;
  reg frameFlooded = 0;
  reg [1:0] limitMode = 0;
  reg [10:0] frameBytes = 0;
  reg [15:0] q;
  wire regWrite, regRead, frameAccept, frameDrop;
  wire [6:0] regAddr;
  wire [15:0] regWdata, regRdata;
  wire [1:0] regByteEn;
  integer miscompares = 0, checked = 0;
  pirl_port_ingress_rate_limiter #(.BUCKET_BYTES(2000)) pirl_port_ingress_rate_limiter_inst (.*);
  pirl_host pirl_host_inst (.*);
  initial forever #4 ref_clk = ~ref_clk;
  task cmp(input [15:0] g, input [15:0] e);
  begin
    checked = checked + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task frame(input p, input [10:0] n, input ok);
  begin
    @(posedge ref_clk);
    {frameStart, framePriority, frameBytes} <= {1'b1, p, n};
    @(posedge ref_clk);
    {frameStart, frameBytes} <= {1'b0, ~n};
    #1 cmp({frameDrop, frameAccept}, {!ok, ok});
  end
  endtask
  task rdc(input [6:0] a, input [15:0] e);
  begin
    pirl_host_inst.rd(a, q);
    cmp(q, e);
  end
  endtask
  task summarize;
  begin
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    rdc(7'h74, 16'h0000);
    repeat (3) frame(1'b0, 11'd1500, 1'b1);
    pirl_host_inst.wr(16'hffff, 2'b11);
    rdc(7'h74, 16'h7f7f);
    rdc(7'h76, 16'h0000);
    pirl_host_inst.wr(16'h0001, 2'b11);
    {countIfg, countPreamble} <= 2'b11;
    // 990 plus 20 overhead bytes fits the 2000 byte bucket once only
    frame(1'b0, 11'd990, 1'b1);
    frame(1'b0, 11'd990, 1'b0);
    limitMode <= 2'b11;
    frame(1'b0, 11'd990, 1'b1);
    frameBroadcast <= 1'b1;
    frame(1'b0, 11'd990, 1'b0);
    pirl_host_inst.wr(16'h6500, 2'b10);
    frame(1'b1, 11'd990, 1'b1);
    frame(1'b1, 11'd990, 1'b0);
    pirl_host_inst.wr(16'h000b, 2'b01);
    rdc(7'h74, 16'h650b);
    frame(1'b0, 11'd1500, 1'b0);
    linkIs100 <= 1'b0;
    repeat (2) @(posedge ref_clk);
    frame(1'b0, 11'd1500, 1'b1);
    pirl_host_inst.wr(16'h0500, 2'b10);
    frame(1'b1, 11'd990, 1'b0);
    frame(1'b1, 11'd100, 1'b1);
    summarize;
  end
endmodule // tb_pirl_port_ingress_rate_limiter

// ### verilog/pirl_defs.vh
// constants for the port 1 ingress rate limiter
`ifndef PIRL_DEFS_VH
`define PIRL_DEFS_VH
`define PIRL_ADDR_RATE 7'h74
`define PIRL_RATE_RESET 16'h0000
`define PIRL_P1_HI 14
`define PIRL_P1_LO 8
`define PIRL_P0_HI 6
`define PIRL_P0_LO 0
`define PIRL_WMASK 16'h7f7f
`define PIRL_CODE_NOLIMIT 7'h00
`define PIRL_CODE_MAX100 7'h64
`define PIRL_CODE_MAX10 7'h0a
`define PIRL_CODE_KBASE 7'h65
`define PIRL_CODE_KTOP 7'h73
`define PIRL_KBPS_STEP 32'd64
`define PIRL_KBPS_PER_MBPS 32'd1000
`define PIRL_KBPS_100M 32'd100000
`define PIRL_KBPS_10M 32'd10000
`define PIRL_CLK_HZ 32'd125000000
`define PIRL_IFG_BYTES 32'd12
`define PIRL_PRE_BYTES 32'd8
`define PIRL_MODE_ALL 2'b00
`define PIRL_MODE_BMF 2'b01
`define PIRL_MODE_BM 2'b10
`define PIRL_MODE_B 2'b11
`define PIRL_CODE_KZERO 7'h64
`define PIRL_BYTE_SCALE 32'd125
`define PIRL_WMASK_HI 8'h7f
`define PIRL_WMASK_LO 8'h7f
`define PIRL_RDATA_NONE 16'h0000
`define PIRL_ACCUM_RESET 32'd0
`define PIRL_COST_PAD 21
`endif

// ### verilog/pirl_port_ingress_rate_limiter.v
// port 1 ingress rate limiter for priorities 0 and 1, token bucket per priority
`timescale 1ns/100ps
`include "pirl_defs.vh"

// one rate code to an allowed rate in kbps; the same table serves both priorities
module pirl_rate_decode (
  input wire [6:0] code,
  input wire speed100,
  output reg [31:0] rateKbps,
  output reg unlimited
);
  reg [31:0] lineKbps;

  // out-of-table codes fall back to line rate so a bad write never blocks traffic
  always @*
  begin
    lineKbps = speed100 ? `PIRL_KBPS_100M : `PIRL_KBPS_10M;
    rateKbps = lineKbps;
    if (code == `PIRL_CODE_NOLIMIT)
      rateKbps = lineKbps;
    else if (code >= `PIRL_CODE_KBASE && code <= `PIRL_CODE_KTOP)
      rateKbps = (code - `PIRL_CODE_KZERO) * `PIRL_KBPS_STEP;
    else if (speed100 && code <= `PIRL_CODE_MAX100)
      rateKbps = code * `PIRL_KBPS_PER_MBPS;
    else if (!speed100 && code <= `PIRL_CODE_MAX10)
      rateKbps = code * `PIRL_KBPS_PER_MBPS;
    // a limit equal to the line rate can never throttle, so the bucket is skipped
    unlimited = (rateKbps == lineKbps);
  end
endmodule // pirl_rate_decode

// byte bucket refilled at rateKbps*125 bytes per second, capped at its depth
module pirl_bucket #(
  parameter BUCKET_BYTES = 4096
)(
  input wire ref_clk,
  input wire resetn,
  input wire [31:0] rateKbps,
  input wire debit,
  input wire [31:0] cost,
  output wire fits
);
  reg [31:0] bucket_q;
  reg [31:0] bucket_d;
  reg [31:0] accum_q;
  reg [31:0] accum_d;
  reg [31:0] step;
  reg [31:0] sum;

  // fractional refill keeps sub-megabit rates exact over long intervals
  always @*
  begin
    step = rateKbps * `PIRL_BYTE_SCALE;
    sum = accum_q + step;
    accum_d = sum;
    bucket_d = bucket_q;
    if (sum >= `PIRL_CLK_HZ)
    begin
      accum_d = sum - `PIRL_CLK_HZ;
      if (bucket_q < BUCKET_BYTES)
        bucket_d = bucket_q + 32'd1;
    end
    // debit is only raised when the frame fits, so this cannot wrap
    if (debit)
      bucket_d = bucket_d - cost;
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bucket_q <= BUCKET_BYTES;
      accum_q <= `PIRL_ACCUM_RESET;
    end
    else
    begin
      bucket_q <= bucket_d;
      accum_q <= accum_d;
    end
  end

  assign fits = (bucket_q >= cost);
endmodule // pirl_bucket

module pirl_port_ingress_rate_limiter #(
  parameter BUCKET_BYTES = 4096
)(
  input wire ref_clk,
  input wire resetn,
  input wire regWrite,
  input wire regRead,
  input wire [6:0] regAddr,
  input wire [15:0] regWdata,
  input wire [1:0] regByteEn,
  output reg [15:0] regRdata,
  input wire linkIs100,
  input wire [1:0] limitMode,
  input wire countIfg,
  input wire countPreamble,
  input wire frameStart,
  input wire framePriority,
  input wire [10:0] frameBytes,
  input wire frameBroadcast,
  input wire frameMulticast,
  input wire frameFlooded,
  output reg frameAccept,
  output reg frameDrop
);
  reg [15:0] rate_q;
  reg speed1_q;
  reg speed_q;
  reg [31:0] cost;
  reg limited;
  reg takeLow;
  reg takeHigh;
  reg frameAccept_d;
  reg frameDrop_d;
  wire [31:0] rateKbpsLow;
  wire [31:0] rateKbpsHigh;
  wire unlimitedLow;
  wire unlimitedHigh;
  wire fitsLow;
  wire fitsHigh;
  wire addrHit = (regAddr == `PIRL_ADDR_RATE);

  // link speed is a status level from another block; synchronise it
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      speed1_q <= 1'b0;
      speed_q <= 1'b0;
    end
    else
    begin
      speed1_q <= linkIs100;
      speed_q <= speed1_q;
    end
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rate_q <= `PIRL_RATE_RESET;
      regRdata <= `PIRL_RDATA_NONE;
    end
    else
    begin
      if (regWrite && addrHit)
      begin
        if (regByteEn[1])
          rate_q[15:8] <= regWdata[15:8] & `PIRL_WMASK_HI;
        if (regByteEn[0])
          rate_q[7:0] <= regWdata[7:0] & `PIRL_WMASK_LO;
      end
      if (regRead)
        regRdata <= addrHit ? rate_q : `PIRL_RDATA_NONE;
    end
  end

  pirl_rate_decode pirl_rate_decode_low (
    .code(rate_q[`PIRL_P0_HI:`PIRL_P0_LO]),
    .speed100(speed_q),
    .rateKbps(rateKbpsLow),
    .unlimited(unlimitedLow)
  );

  pirl_rate_decode pirl_rate_decode_high (
    .code(rate_q[`PIRL_P1_HI:`PIRL_P1_LO]),
    .speed100(speed_q),
    .rateKbps(rateKbpsHigh),
    .unlimited(unlimitedHigh)
  );

  pirl_bucket #(
    .BUCKET_BYTES(BUCKET_BYTES)
  ) pirl_bucket_low (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .rateKbps(rateKbpsLow),
    .debit(takeLow),
    .cost(cost),
    .fits(fitsLow)
  );

  pirl_bucket #(
    .BUCKET_BYTES(BUCKET_BYTES)
  ) pirl_bucket_high (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .rateKbps(rateKbpsHigh),
    .debit(takeHigh),
    .cost(cost),
    .fits(fitsHigh)
  );

  // frame cost in bytes and whether this frame kind is limited
  always @*
  begin
    cost = {{`PIRL_COST_PAD{1'b0}}, frameBytes};
    if (countIfg)
      cost = cost + `PIRL_IFG_BYTES;
    if (countPreamble)
      cost = cost + `PIRL_PRE_BYTES;
    case (limitMode)
      `PIRL_MODE_ALL: limited = 1'b1;
      `PIRL_MODE_BMF: limited = frameBroadcast | frameMulticast | frameFlooded;
      `PIRL_MODE_BM: limited = frameBroadcast | frameMulticast;
      `PIRL_MODE_B: limited = frameBroadcast;
      default: limited = 1'b1;
    endcase
  end

  // decision: frames outside the mode or at an unlimited code pass untouched
  always @*
  begin
    frameAccept_d = 1'b0;
    frameDrop_d = 1'b0;
    takeLow = 1'b0;
    takeHigh = 1'b0;
    if (frameStart)
    begin
      if (!limited || (framePriority ? unlimitedHigh : unlimitedLow))
        frameAccept_d = 1'b1;
      else if (framePriority ? fitsHigh : fitsLow)
      begin
        frameAccept_d = 1'b1;
        takeHigh = framePriority;
        takeLow = !framePriority;
      end
      else
        frameDrop_d = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      frameAccept <= 1'b0;
      frameDrop <= 1'b0;
    end
    else
    begin
      frameAccept <= frameAccept_d;
      frameDrop <= frameDrop_d;
    end
  end
endmodule // pirl_port_ingress_rate_limiter
